// ---- hw/adcsr_map.vh ----
// register map, field positions and reset values of the converter status bank
`ifndef ADCSR_MAP_VH
`define ADCSR_MAP_VH

// register addresses
`define ADCSR_ADDR_STATUS    8'hd8
`define ADCSR_ADDR_MODE      8'hd1
`define ADCSR_ADDR_DECIM     8'hd4
`define ADCSR_ADDR_RES0_L    8'hd9
`define ADCSR_ADDR_RES0_M    8'hda
`define ADCSR_ADDR_RES0_H    8'hdb
`define ADCSR_ADDR_RES1_L    8'hdc
`define ADCSR_ADDR_RES1_H    8'hdd
`define ADCSR_ADDR_OFS0_L    8'he1
`define ADCSR_ADDR_OFS0_M    8'he2
`define ADCSR_ADDR_OFS0_H    8'he3
`define ADCSR_ADDR_OFS1_L    8'he4
`define ADCSR_ADDR_OFS1_H    8'he5
`define ADCSR_ADDR_GAIN0_L   8'he9
`define ADCSR_ADDR_GAIN0_M   8'hea
`define ADCSR_ADDR_GAIN0_H   8'heb
`define ADCSR_ADDR_GAIN1_L   8'hec
`define ADCSR_ADDR_GAIN1_H   8'hed

// low nibbles of bit-addressable addresses
`define ADCSR_BITADDR_NIB0   4'h0
`define ADCSR_BITADDR_NIB8   4'h8

// status register bit positions
`define ADCSR_BIT_PRIMARY_READY_FLAG       3'd7
`define ADCSR_BIT_AUXILIARY_READY_FLAG       3'd6
`define ADCSR_BIT_CAL        3'd5
`define ADCSR_BIT_NOREF      3'd4
`define ADCSR_BIT_PRIMARY_ERROR_FLAG       3'd3
`define ADCSR_BIT_AUXILIARY_ERROR_FLAG       3'd2

// mode register fields
`define ADCSR_BIT_EN0        3'd5
`define ADCSR_BIT_EN1        3'd4
`define ADCSR_MODE_MASK      8'h37
`define ADCSR_MD_PWRDN       3'h0
`define ADCSR_MD_IDLE        3'h1
`define ADCSR_MD_SINGLE      3'h2
`define ADCSR_MD_CONT        3'h3

// coefficient word indices
`define ADCSR_COEF_OFS0      2'd0
`define ADCSR_COEF_OFS1      2'd1
`define ADCSR_COEF_GAIN0     2'd2
`define ADCSR_COEF_GAIN1     2'd3

// reset values
`define ADCSR_RST_STATUS     8'h00
`define ADCSR_RST_MODE       8'h00
`define ADCSR_RST_DECIM      8'h80
`define ADCSR_RST_OFS0       24'h80_0000
`define ADCSR_RST_OFS1       24'h00_8000
`define ADCSR_RST_GAIN0      24'h50_0000
`define ADCSR_RST_GAIN1      24'h00_5000
`define ADCSR_UNMAPPED_READ  8'h00
`define ADCSR_ONES24         24'hff_ffff
`define ADCSR_ONES16         24'h00_ffff

`endif

// ---- hw/adcsr_coef_mem.v ----
// calibration coefficient store with factory preload and registered byte read
`timescale 1ns/100ps
`include "adcsr_map.vh"

module adcsr_coef_mem #(
	parameter [95:0] INIT = {`ADCSR_RST_GAIN1, `ADCSR_RST_GAIN0,
	                         `ADCSR_RST_OFS1, `ADCSR_RST_OFS0}
) (
	// clock and reset
	input  wire        clock,
	input  wire        reset_n,
	// software byte write
	input  wire        cpuWe,
	input  wire [1:0]  cpuIdx,
	input  wire [1:0]  cpuLane,
	input  wire [7:0]  cpuData,
	// engine word write, one enable per word, data per channel
	input  wire [3:0]  engWe,
	input  wire [47:0] engData,
	// byte read
	input  wire [1:0]  rdIdx,
	input  wire [1:0]  rdLane,
	output reg  [7:0]  rdData,
	// all words
	output wire [95:0] coefFlat
);

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : gWord
			reg [23:0] word_r;
			always @(posedge clock) begin
				if (!reset_n) begin
					word_r <= INIT[i*24 +: 24];
				end else if (engWe[i]) begin
					word_r <= engData[(i%2)*24 +: 24];
				end else if (cpuWe && cpuIdx == i) begin
					case (cpuLane)
						2'd0: word_r[7:0] <= cpuData;
						2'd1: word_r[15:8] <= cpuData;
						default: word_r[23:16] <= cpuData;
					endcase
				end
			end
			assign coefFlat[i*24 +: 24] = word_r;
		end
	endgenerate

	reg [23:0] selWord;
	always @* begin
		case (rdIdx)
			2'd0: selWord = coefFlat[23:0];
			2'd1: selWord = coefFlat[47:24];
			2'd2: selWord = coefFlat[71:48];
			default: selWord = coefFlat[95:72];
		endcase
	end

	always @(posedge clock) begin
		if (!reset_n) begin
			rdData <= 8'h00;
		end else begin
			case (rdLane)
				2'd0: rdData <= selWord[7:0];
				2'd1: rdData <= selWord[15:8];
				default: rdData <= selWord[23:16];
			endcase
		end
	end

endmodule

// ---- hw/adcsr_bank.v ----
// converter status, mode, result and coefficient register bank
`timescale 1ns/100ps
`include "adcsr_map.vh"

module adcsr_bank #(
	parameter [95:0] FACTORY_COEF = {`ADCSR_RST_GAIN1, `ADCSR_RST_GAIN0,
	                                 `ADCSR_RST_OFS1, `ADCSR_RST_OFS0}
) (
	// clock and reset
	input  wire        clock,
	input  wire        reset_n,
	// special function register access
	input  wire [7:0]  sfrAddr,
	input  wire [7:0]  sfrWrData,
	input  wire        sfrWrite,
	input  wire        sfrRead,
	input  wire        sfrBitWrite,
	input  wire [2:0]  sfrBitSel,
	input  wire        sfrBitVal,
	output reg  [7:0]  sfrRdData,
	output reg         sfrRdBit,
	output reg         sfrRdValid,
	// converter control
	output wire        primaryEnable,
	output wire        auxiliaryEnable,
	output wire [2:0]  modeSelect,
	output reg         convStart,
	output wire [7:0]  decimationFactor,
	// reference monitor
	input  wire        referenceInvalid,
	input  wire        externalRefSelected,
	// primary engine
	input  wire        priConvDone,
	input  wire [23:0] priConvData,
	input  wire        priConvClamped,
	input  wire        priCalDone,
	input  wire        priCalGain,
	input  wire [23:0] priCalData,
	input  wire        priCalError,
	// auxiliary engine
	input  wire        auxConvDone,
	input  wire [15:0] auxConvData,
	input  wire        auxConvClamped,
	input  wire        auxCalDone,
	input  wire        auxCalGain,
	input  wire [15:0] auxCalData,
	input  wire        auxCalError,
	// results and coefficients toward the engines
	output wire [23:0] primaryResult,
	output wire [15:0] auxiliaryResult,
	output wire [23:0] primaryOffsetCoef,
	output wire [15:0] auxiliaryOffsetCoef,
	output wire [23:0] primaryGainCoef,
	output wire [15:0] auxiliaryGainCoef
);

	reg  [7:0]  mode_r;
	reg  [7:0]  decim_r;
	reg         cal_r;
	reg         noRef_r;
	reg  [7:0]  local_r;
	reg         fromMem_r;
	reg         rdPend_r;
	reg  [2:0]  bitSel_r;

	wire [1:0]  rdyV;
	wire [1:0]  errV;
	wire [1:0]  startV;
	wire [47:0] resultV;
	wire [3:0]  engWe;
	wire [95:0] coefFlat;
	wire [7:0]  memRdData;

	wire [1:0]  convDoneV = {auxConvDone, priConvDone};
	wire [1:0]  convClampV = {auxConvClamped, priConvClamped};
	wire [1:0]  calDoneV = {auxCalDone, priCalDone};
	wire [1:0]  calGainV = {auxCalGain, priCalGain};
	wire [1:0]  calErrV = {auxCalError, priCalError};
	wire [47:0] convDataV = {8'h00, auxConvData, priConvData};
	wire [47:0] calDataV = {8'h00, auxCalData, priCalData};

	// byte and bit access decode
	wire        bitAddrOk = sfrAddr[3:0] == `ADCSR_BITADDR_NIB0 ||
	                        sfrAddr[3:0] == `ADCSR_BITADDR_NIB8;
	wire        statWrite = sfrWrite && sfrAddr == `ADCSR_ADDR_STATUS;
	wire        statBitWrite = sfrBitWrite && bitAddrOk &&
	                           sfrAddr == `ADCSR_ADDR_STATUS;
	wire        modeWrite = sfrWrite && sfrAddr == `ADCSR_ADDR_MODE;
	wire        startMode = sfrWrData[2:0] >= `ADCSR_MD_SINGLE;
	wire        anyStart = |startV;
	wire        forceOnes = noRef_r && externalRefSelected;

	assign primaryEnable = mode_r[`ADCSR_BIT_EN0];
	assign auxiliaryEnable = mode_r[`ADCSR_BIT_EN1];
	assign modeSelect = mode_r[2:0];
	assign decimationFactor = decim_r;
	assign primaryResult = resultV[23:0];
	assign auxiliaryResult = resultV[39:24];
	assign primaryOffsetCoef = coefFlat[23:0];
	assign auxiliaryOffsetCoef = coefFlat[39:24];
	assign primaryGainCoef = coefFlat[71:48];
	assign auxiliaryGainCoef = coefFlat[87:72];

	// per converter ready, error and result
	// a set ready flag freezes this channel's result and coefficients
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gCh
			reg         rdy_r;
			reg         err_r;
			reg  [23:0] result_r;
			wire [2:0]  rdyPos = (g == 0) ? `ADCSR_BIT_PRIMARY_READY_FLAG : `ADCSR_BIT_AUXILIARY_READY_FLAG;
			wire [2:0]  enPos = (g == 0) ? `ADCSR_BIT_EN0 : `ADCSR_BIT_EN1;
			wire [23:0] ones = (g == 0) ? `ADCSR_ONES24 : `ADCSR_ONES16;
			wire        swClr = (statWrite && !sfrWrData[rdyPos]) ||
			                    (statBitWrite && sfrBitSel == rdyPos && !sfrBitVal);
			wire        start = modeWrite && startMode && sfrWrData[enPos];
			wire        evSet = convDoneV[g] || calDoneV[g];
			wire        accept = evSet && !rdy_r;
			wire        clampEv = convDoneV[g] && (convClampV[g] || forceOnes);
			wire        calEv = calDoneV[g] && calErrV[g];
			wire        coefWr = calDoneV[g] && accept && !calErrV[g];

			always @(posedge clock) begin
				if (!reset_n) begin
					rdy_r <= 1'b0;
					err_r <= 1'b0;
					result_r <= 24'h00_0000;
				end else begin
					rdy_r <= evSet || (rdy_r && !(swClr || start));
					err_r <= (accept && (clampEv || calEv)) ||
					         (err_r && !start);
					if (convDoneV[g] && accept) begin
						result_r <= forceOnes ? ones : (convDataV[g*24 +: 24] & ones);
					end
				end
			end

			assign rdyV[g] = rdy_r;
			assign errV[g] = err_r;
			assign startV[g] = start;
			assign resultV[g*24 +: 24] = result_r;
			assign engWe[g] = coefWr && !calGainV[g];
			assign engWe[g+2] = coefWr && calGainV[g];
		end
	endgenerate

	// mode, decimation, calibration-done and reference flags
	always @(posedge clock) begin
		if (!reset_n) begin
			mode_r <= `ADCSR_RST_MODE;
			decim_r <= `ADCSR_RST_DECIM;
			cal_r <= 1'b0;
			noRef_r <= 1'b0;
			convStart <= 1'b0;
		end else begin
			// a mode write outranks the single-shot return to power-down
			if (modeWrite) begin
				mode_r <= sfrWrData & `ADCSR_MODE_MASK;
			end else if (mode_r[2:0] == `ADCSR_MD_SINGLE && |convDoneV) begin
				mode_r[2:0] <= `ADCSR_MD_PWRDN;
			end
			if (sfrWrite && sfrAddr == `ADCSR_ADDR_DECIM) begin
				decim_r <= sfrWrData;
			end
			cal_r <= (|calDoneV) || (cal_r && !anyStart);
			// missing reference is a level, one edge behind the enables
			noRef_r <= (mode_r[`ADCSR_BIT_EN0] || mode_r[`ADCSR_BIT_EN1]) &&
			           referenceInvalid;
			convStart <= anyStart;
		end
	end

	// coefficient address decode
	reg         coefHit;
	reg  [1:0]  coefIdx;
	reg  [1:0]  coefLane;
	always @* begin
		coefHit = 1'b1;
		coefIdx = `ADCSR_COEF_OFS0;
		coefLane = 2'd0;
		case (sfrAddr)
			`ADCSR_ADDR_OFS0_L: coefLane = 2'd0;
			`ADCSR_ADDR_OFS0_M: coefLane = 2'd1;
			`ADCSR_ADDR_OFS0_H: coefLane = 2'd2;
			`ADCSR_ADDR_OFS1_L: coefIdx = `ADCSR_COEF_OFS1;
			`ADCSR_ADDR_OFS1_H: begin
				coefIdx = `ADCSR_COEF_OFS1;
				coefLane = 2'd1;
			end
			`ADCSR_ADDR_GAIN0_L: coefIdx = `ADCSR_COEF_GAIN0;
			`ADCSR_ADDR_GAIN0_M: begin
				coefIdx = `ADCSR_COEF_GAIN0;
				coefLane = 2'd1;
			end
			`ADCSR_ADDR_GAIN0_H: begin
				coefIdx = `ADCSR_COEF_GAIN0;
				coefLane = 2'd2;
			end
			`ADCSR_ADDR_GAIN1_L: coefIdx = `ADCSR_COEF_GAIN1;
			`ADCSR_ADDR_GAIN1_H: begin
				coefIdx = `ADCSR_COEF_GAIN1;
				coefLane = 2'd1;
			end
			default: coefHit = 1'b0;
		endcase
	end

	adcsr_coef_mem #(
		.INIT     (FACTORY_COEF)
	) uCoef (
		.clock    (clock),
		.reset_n  (reset_n),
		.cpuWe    (sfrWrite && coefHit),
		.cpuIdx   (coefIdx),
		.cpuLane  (coefLane),
		.cpuData  (sfrWrData),
		.engWe    (engWe),
		.engData  (calDataV),
		.rdIdx    (coefIdx),
		.rdLane   (coefLane),
		.rdData   (memRdData),
		.coefFlat (coefFlat)
	);

	// status byte assembled from the flag positions
	reg  [7:0]  statusByte;
	always @* begin
		statusByte = `ADCSR_RST_STATUS;
		statusByte[`ADCSR_BIT_PRIMARY_READY_FLAG] = rdyV[0];
		statusByte[`ADCSR_BIT_AUXILIARY_READY_FLAG] = rdyV[1];
		statusByte[`ADCSR_BIT_CAL] = cal_r;
		statusByte[`ADCSR_BIT_NOREF] = noRef_r;
		statusByte[`ADCSR_BIT_PRIMARY_ERROR_FLAG] = errV[0];
		statusByte[`ADCSR_BIT_AUXILIARY_ERROR_FLAG] = errV[1];
	end

	// local read selection
	reg  [7:0]  localByte;
	always @* begin
		case (sfrAddr)
			`ADCSR_ADDR_STATUS: localByte = statusByte;
			`ADCSR_ADDR_MODE:   localByte = mode_r;
			`ADCSR_ADDR_DECIM:  localByte = decim_r;
			`ADCSR_ADDR_RES0_L: localByte = resultV[7:0];
			`ADCSR_ADDR_RES0_M: localByte = resultV[15:8];
			`ADCSR_ADDR_RES0_H: localByte = resultV[23:16];
			`ADCSR_ADDR_RES1_L: localByte = resultV[31:24];
			`ADCSR_ADDR_RES1_H: localByte = resultV[39:32];
			default:            localByte = `ADCSR_UNMAPPED_READ;
		endcase
	end

	// two-stage read: select, then present
	// coefficient bytes come from a registered store, so every read takes two edges
	always @(posedge clock) begin
		if (!reset_n) begin
			local_r <= 8'h00;
			fromMem_r <= 1'b0;
			rdPend_r <= 1'b0;
			bitSel_r <= 3'd0;
			sfrRdData <= 8'h00;
			sfrRdBit <= 1'b0;
			sfrRdValid <= 1'b0;
		end else begin
			rdPend_r <= sfrRead;
			if (sfrRead) begin
				local_r <= localByte;
				fromMem_r <= coefHit;
				bitSel_r <= sfrBitSel;
			end
			sfrRdValid <= rdPend_r;
			if (rdPend_r) begin
				sfrRdData <= fromMem_r ? memRdData : local_r;
				sfrRdBit <= fromMem_r ? memRdData[bitSel_r] : local_r[bitSel_r];
			end
		end
	end

endmodule

// ---- tb/adcsr_bank_props.sv ----
// assertions on the converter status bank ports
`timescale 1ns/100ps
module adcsr_bank_props (
	// clock and reset
	input wire        clock,
	input wire        reset_n,
	// register access
	input wire [7:0]  sfrAddr,
	input wire [7:0]  sfrWrData,
	input wire        sfrWrite,
	input wire        sfrRead,
	input wire [2:0]  sfrBitSel,
	input wire [7:0]  sfrRdData,
	input wire        sfrRdBit,
	input wire        sfrRdValid,
	// control and results
	input wire [2:0]  modeSelect,
	input wire        convStart,
	input wire [7:0]  decimationFactor,
	input wire        priConvDone,
	input wire [23:0] primaryResult
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_rdlat;
		sfrRead |-> ##2 sfrRdValid;
	endproperty
	a_rdlat: assert property (p_rdlat) else $error("read answer late");
	property p_rdbit;
		sfrRead |-> ##2 (sfrRdBit == sfrRdData[$past(sfrBitSel, 2)]);
	endproperty
	a_rdbit: assert property (p_rdbit) else $error("bit read wrong");
	property p_unmap;
		sfrRead && sfrAddr == 8'h80 |-> ##2 sfrRdData == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
	property p_rsv;
		sfrRead && sfrAddr == 8'hd8 |-> ##2 sfrRdData[1:0] == 2'b00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_mode;
		sfrWrite && sfrAddr == 8'hd1 |=> {5'h00, modeSelect} == ($past(sfrWrData) & 8'h07);
	endproperty
	a_mode: assert property (p_mode) else $error("mode write lost");
	wire startWr = sfrWrite && sfrAddr == 8'hd1 && sfrWrData[5:4] != 2'b00 &&
	               sfrWrData[2:0] >= 3'd2;
	property p_start;
		startWr |=> convStart ##1 (!convStart || $past(startWr));
	endproperty
	a_start: assert property (p_start) else $error("start pulse wrong");
	property p_single;
		priConvDone && modeSelect == 3'd2 && !(sfrWrite && sfrAddr == 8'hd1)
			|=> modeSelect == 3'd0;
	endproperty
	a_single: assert property (p_single) else $error("single mode not ended");
	property p_hold;
		!$stable(primaryResult) |-> $past(priConvDone);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed without event");
	property p_decim;
		sfrWrite && sfrAddr == 8'hd4 |=> decimationFactor == $past(sfrWrData);
	endproperty
	a_decim: assert property (p_decim) else $error("decimation write lost");
endmodule

bind adcsr_bank adcsr_bank_props u_props (.clock, .reset_n, .sfrAddr, .sfrWrData, .sfrWrite,
	.sfrRead, .sfrBitSel, .sfrRdData, .sfrRdBit, .sfrRdValid, .modeSelect, .convStart,
	.decimationFactor, .priConvDone, .primaryResult);

// ---- tb/adcsr_eng_model.sv ----
// behavioural conversion and calibration engines of both channels
`timescale 1ns/100ps
module adcsr_eng_model #(
	parameter DELAY = 3
) (
	// clock and mode
	input  wire        clock,
	input  wire        primaryEnable,
	input  wire        auxiliaryEnable,
	input  wire [2:0]  modeSelect,
	// commanded outcome
	input  wire [23:0] priVal,
	input  wire [15:0] auxVal,
	input  wire        clampReq,
	input  wire        errReq,
	// engine events
	output reg         priConvDone = 1'b0,
	output reg         priCalDone = 1'b0,
	output reg         auxConvDone = 1'b0,
	output reg         auxCalDone = 1'b0,
	output reg  [23:0] priConvData,
	output reg  [23:0] priCalData,
	output reg  [15:0] auxConvData,
	output reg  [15:0] auxCalData,
	output reg         priConvClamped,
	output reg         auxConvClamped,
	output reg         priCalError,
	output reg         auxCalError,
	output reg         priCalGain,
	output reg         auxCalGain
);
	reg  [3:0] cnt = 4'h0;
	wire       run = (primaryEnable | auxiliaryEnable) && modeSelect >= 3'd2;
	wire       fire = run && cnt == DELAY;
	wire       cal = modeSelect[2];
	always @(posedge clock) begin
		cnt <= (run && !fire) ? cnt + 4'h1 : 4'h0;
		priConvDone <= fire & primaryEnable & !cal;
		priCalDone <= fire & primaryEnable & cal;
		auxConvDone <= fire & auxiliaryEnable & !cal;
		auxCalDone <= fire & auxiliaryEnable & cal;
		// data lines scramble outside an event
		priConvData <= fire ? priVal : ~priConvData;
		priCalData <= fire ? priVal : ~priCalData;
		auxConvData <= fire ? auxVal : ~auxConvData;
		auxCalData <= fire ? auxVal : ~auxCalData;
		priConvClamped <= fire & clampReq;
		auxConvClamped <= fire & clampReq;
		priCalError <= fire & errReq;
		auxCalError <= fire & errReq;
		priCalGain <= modeSelect[0];
		auxCalGain <= modeSelect[0];
	end
endmodule

// ---- tb/tb_adcsr_bank.sv ----
// self-checking bench for the converter status register bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin totalChecks = totalChecks + 1; if ((g) !== (e)) begin failCount = failCount + 1; $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_adcsr_bank;
	reg         clock = 1'b0;
	reg         reset_n = 1'b0;
	reg  [7:0]  sfrAddr = 8'h00;
	reg  [7:0]  sfrWrData = 8'h00;
	reg         sfrWrite = 1'b0;
	reg         sfrRead = 1'b0;
	reg         sfrBitWrite = 1'b0;
	reg  [2:0]  sfrBitSel = 3'd0;
	reg         sfrBitVal = 1'b0;
	reg         referenceInvalid = 1'b0;
	reg         externalRefSelected = 1'b0;
	reg  [23:0] priVal = 24'h12_3456;
	reg  [15:0] auxVal = 16'h9876;
	reg         clampReq = 1'b0;
	reg         errReq = 1'b0;
	wire [7:0]  sfrRdData;
	wire [2:0]  modeSelect;
	wire [23:0] priConvData, priCalData;
	wire [15:0] auxConvData, auxCalData;
	wire        sfrRdBit, sfrRdValid, primaryEnable, auxiliaryEnable;
	wire        priConvDone, priConvClamped, priCalDone, priCalGain, priCalError;
	wire        auxConvDone, auxConvClamped, auxCalDone, auxCalGain, auxCalError;
	wire [23:0] primaryOffsetCoef, primaryGainCoef;
	wire [15:0] auxiliaryResult, auxiliaryOffsetCoef, auxiliaryGainCoef;
	integer     failCount = 0;
	integer     totalChecks = 0;

	always #5 clock = ~clock;

	adcsr_bank DUT (.clock, .reset_n, .sfrAddr, .sfrWrData, .sfrWrite, .sfrRead, .sfrBitWrite,
		.sfrBitSel, .sfrBitVal, .sfrRdData, .sfrRdBit, .sfrRdValid, .primaryEnable,
		.auxiliaryEnable, .modeSelect, .convStart(), .decimationFactor(), .referenceInvalid,
		.externalRefSelected, .priConvDone, .priConvData, .priConvClamped, .priCalDone,
		.priCalGain, .priCalData, .priCalError, .auxConvDone, .auxConvData, .auxConvClamped,
		.auxCalDone, .auxCalGain, .auxCalData, .auxCalError, .primaryResult(),
		.auxiliaryResult, .primaryOffsetCoef, .auxiliaryOffsetCoef, .primaryGainCoef,
		.auxiliaryGainCoef);

	adcsr_eng_model engine (.clock, .primaryEnable, .auxiliaryEnable, .modeSelect, .priVal,
		.auxVal, .clampReq, .errReq, .priConvDone, .priCalDone, .auxConvDone, .auxCalDone,
		.priConvData, .priCalData, .auxConvData, .auxCalData, .priConvClamped,
		.auxConvClamped, .priCalError, .auxCalError, .priCalGain, .auxCalGain);

	task finish_test;
		begin
			if (failCount == 0 && totalChecks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge clock);
			sfrAddr = a;
			sfrWrData = d;
			sfrWrite = 1'b1;
			@(negedge clock);
			sfrWrite = 1'b0;
		end
	endtask

	task bw(input [2:0] b, input v);
		begin
			@(negedge clock);
			sfrAddr = 8'hd8;
			sfrBitSel = b;
			sfrBitVal = v;
			sfrBitWrite = 1'b1;
			@(negedge clock);
			sfrBitWrite = 1'b0;
		end
	endtask

	task rd(input [7:0] a, input [7:0] e);
		integer i;
		begin
			@(negedge clock);
			sfrAddr = a;
			sfrRead = 1'b1;
			@(negedge clock);
			sfrRead = 1'b0;
			for (i = 0; i < 4 && sfrRdValid !== 1'b1; i = i + 1)
				@(negedge clock);
			if (i == 4) begin
				failCount = failCount + 1;
				finish_test;
			end else
				`CHK($sformatf("reg %h", a), e, sfrRdData)
		end
	endtask

	// stop engines, clear ready, then start
	task go(input [7:0] m);
		begin
			wr(8'hd1, 8'h00);
			wr(8'hd8, 8'h00);
			wr(8'hd1, m);
			repeat (10) @(negedge clock);
		end
	endtask

	initial begin
		repeat (12) @(negedge clock);
		reset_n = 1'b1;
		rd(8'hd8, 8'h00);
		rd(8'hd1, 8'h00);
		rd(8'hd4, 8'h80);
		rd(8'he3, 8'h80);
		rd(8'heb, 8'h50);
		rd(8'he5, 8'h80);
		rd(8'hed, 8'h50);
		`CHK("gain0", 24'h50_0000, primaryGainCoef)
		wr(8'he1, 8'h5a);
		rd(8'he1, 8'h5a);
		`CHK("ofs0", 24'h80_005a, primaryOffsetCoef)
		`CHK("ofs1", 16'h8000, auxiliaryOffsetCoef)
		wr(8'hed, 8'ha5);
		rd(8'hed, 8'ha5);
		`CHK("gain1", 16'ha500, auxiliaryGainCoef)
		rd(8'h80, 8'h00);
		wr(8'hd4, 8'h40);
		rd(8'hd4, 8'h40);
		go(8'h22);
		rd(8'hd8, 8'h80);
		rd(8'hd1, 8'h20);
		rd(8'hdb, 8'h12);
		rd(8'hda, 8'h34);
		rd(8'hd9, 8'h56);
		wr(8'hd8, 8'hff);
		rd(8'hd8, 8'h80);
		wr(8'hd8, 8'h00);
		rd(8'hd8, 8'h00);
		go(8'h23);
		priVal = 24'hab_cdef;
		repeat (8) @(negedge clock);
		rd(8'hdb, 8'h12);
		wr(8'hd1, 8'h20);
		bw(3'd7, 1'b0);
		rd(8'hd8, 8'h00);
		clampReq = 1'b1;
		go(8'h12);
		rd(8'hd8, 8'h44);
		rd(8'hdd, 8'h98);
		`CHK("aux result", 16'h9876, auxiliaryResult)
		clampReq = 1'b0;
		priVal = 24'h11_2233;
		go(8'h24);
		rd(8'hd8, 8'ha4);
		rd(8'he3, 8'h11);
		`CHK("ofs0 cal", 24'h11_2233, primaryOffsetCoef)
		errReq = 1'b1;
		go(8'h25);
		rd(8'hd8, 8'hac);
		rd(8'heb, 8'h50);
		`CHK("gain0 kept", 24'h50_0000, primaryGainCoef)
		errReq = 1'b0;
		go(8'h32);
		rd(8'hd8, 8'hc0);
		referenceInvalid = 1'b1;
		externalRefSelected = 1'b1;
		go(8'h22);
		rd(8'hd8, 8'h98);
		rd(8'hd9, 8'hff);
		referenceInvalid = 1'b0;
		rd(8'hd8, 8'h88);
		finish_test;
	end
endmodule
